/* File: core/dcc_pkg.sv */
// constants, register map and types of the dual comparator control block
// Notes on behaviour
// - each result is high when positive input exceeds negative, low when below
// - mode 010 routes the internal reference to both positive inputs
// - both results readable in comparator_control; writes to those bits ignored
// - mode 110 drives port A pins three and four with raw results
// - port A direction bits still gate the drivers of those two pins
// - port data reads return 0 on pins the mode makes analog
// - flag sets whenever a result differs from the last latched reference
// - flag is bit 6 of peripheral_flags; write 0 clears, 1 sets
// - request needs comparator, peripheral and global enables; flag sets regardless
// - a change coinciding with a control register read may not set the flag; here the mismatch of that same cycle still sets it
// - any comparator_control access latches the present results as reference
// - mismatch keeps setting the flag; software must access control before clearing
// - comparators run during sleep; an enabled comparator interrupt wakes the device
// - mode 111 switches both comparators off
// - wake-up from sleep leaves comparator_control unchanged
// - reset returns comparator_control to mode 000, port A pins zero to three analog, pin four digital
// - comparators stay powered down throughout reset
// - result two bit 7, result one bit 6, switch bit 3, mode bits 2..0
`default_nettype none
package dcc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // printed offsets are register indices; byte address is four times that
  localparam logic [9:0] IDX_INTC = 10'h00B;
  localparam logic [9:0] IDX_PFLAGS = 10'h00C;
  localparam logic [9:0] IDX_CMC = 10'h01F;
  localparam logic [9:0] IDX_PDIR = 10'h085;
  localparam logic [9:0] IDX_PEN = 10'h08C;
  localparam logic [9:0] IDX_PDATA = 10'h005;
  localparam logic [ADDR_W-1:0] ADDR_INTC = {IDX_INTC, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PFLAGS = {IDX_PFLAGS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CMC = {IDX_CMC, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PDIR = {IDX_PDIR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PEN = {IDX_PEN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PDATA = {IDX_PDATA, 2'h0};
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int FLAG_BIT = 6;
  localparam int CMP_EN_BIT = 6;
  localparam int RES2_BIT = 7;
  localparam int RES1_BIT = 6;
  localparam int SW_BIT = 3;
  localparam logic [7:0] INTC_RST = 8'h00;
  localparam logic [4:0] PDIR_RST = 5'h1F;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_VREF = 3'h2;
  localparam logic [2:0] MODE_PINS = 3'h6;
  localparam logic [2:0] MODE_OFF = 3'h7;
  // pins taken as analog inputs per mode group
  localparam logic [4:0] ANA_MASK_OFF = 5'h00;
  localparam logic [4:0] ANA_MASK_PINS = 5'h07;
  localparam logic [4:0] ANA_MASK_DEF = 5'h0F;
  typedef struct packed {
    logic input_switch;
    logic [2:0] mode;
  } dcc_cfg_t;
  localparam dcc_cfg_t CFG_RST = '{input_switch: 1'b0, mode: MODE_RESET};
endpackage
`default_nettype wire

/* File: core/dcc_top.sv */
// apb-reached control, flag and pin logic of the two-comparator module
`default_nettype none
module dcc_top
  import dcc_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [DATA_W-1:0] PWDATA_I,
  output logic [DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic CMP1_RAW_I,
  input wire logic CMP2_RAW_I,
  input wire logic [4:0] PA_PIN_I,
  output dcc_cfg_t CFG_O,
  output logic VREF_TO_POS_O,
  output logic CMP_POWER_DOWN_O,
  output logic PA_CMP_SEL_O,
  output logic [1:0] PA_CMP_OUT_O,
  output logic [1:0] PA_OE_O,
  output logic IRQ_O,
  output logic WAKE_O
);
  logic [1:0] res_s1_reg;
  logic [1:0] res_s2_reg;
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic [1:0] ref_reg;
  logic [1:0] ref_next;
  logic flag_reg;
  logic flag_next;
  logic cmp_irq_en_reg;
  logic [7:0] intc_reg;
  logic [4:0] pdir_reg;
  dcc_cfg_t cfg_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // results come straight from the analog side, asynchronous to the core
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      res_s1_reg <= 2'h0;
      res_s2_reg <= 2'h0;
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
    end else begin
      res_s1_reg <= {CMP2_RAW_I, CMP1_RAW_I};
      res_s2_reg <= res_s1_reg;
      pin_s1_reg <= PA_PIN_I;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire setup = PSEL_I & ~PENABLE_I;
  wire acc = PSEL_I & PENABLE_I;
  wire hit_intc = PADDR_I == ADDR_INTC;
  wire hit_pflags = PADDR_I == ADDR_PFLAGS;
  wire hit_cmc = PADDR_I == ADDR_CMC;
  wire hit_pdir = PADDR_I == ADDR_PDIR;
  wire hit_pen = PADDR_I == ADDR_PEN;
  wire hit_pdata = PADDR_I == ADDR_PDATA;
  wire mapped = hit_intc | hit_pflags | hit_cmc | hit_pdir | hit_pen | hit_pdata;
  wire wr = acc & PWRITE_I & mapped;
  wire cmc_access = acc & hit_cmc;
  wire mismatch = res_s2_reg != ref_reg;
  wire [4:0] ana_mask = (cfg_reg.mode == MODE_OFF) ? ANA_MASK_OFF :
                        (cfg_reg.mode == MODE_PINS) ? ANA_MASK_PINS : ANA_MASK_DEF;
  wire [7:0] cmc_view = {res_s2_reg[1], res_s2_reg[0], 2'h0, cfg_reg};
  wire [7:0] pflags_view = {1'b0, flag_reg, 6'h00};
  wire [7:0] pen_view = {1'b0, cmp_irq_en_reg, 6'h00};
  wire [7:0] pdata_view = {3'h0, pin_s2_reg & ~ana_mask};
  wire [7:0] rd_sel = hit_intc ? intc_reg :
                      hit_pflags ? pflags_view :
                      hit_cmc ? cmc_view :
                      hit_pdir ? {3'h0, pdir_reg} :
                      hit_pen ? pen_view :
                      hit_pdata ? pdata_view : 8'h00;

  // read data is captured in the setup cycle so the access phase needs no wait
  assign rdata_next = (setup & ~PWRITE_I) ? {24'h000000, rd_sel} : rdata_reg;
  // any access, read or write, ends the mismatch; a change in the access cycle still sets the flag
  assign ref_next = cmc_access ? res_s2_reg : ref_reg;
  // set wins over software clear; a live mismatch keeps setting the flag
  assign flag_next = mismatch | ((wr & hit_pflags) ? PWDATA_I[FLAG_BIT] : flag_reg);

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ref_reg <= 2'h0;
      flag_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ref_reg <= ref_next;
      flag_reg <= flag_next;
      rdata_reg <= rdata_next;
    end
  end

  // sleep is not seen here: nothing below depends on it, so contents survive wake-up
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      cfg_reg <= CFG_RST;
      intc_reg <= INTC_RST;
      cmp_irq_en_reg <= 1'b0;
      pdir_reg <= PDIR_RST;
    end else begin
      if (wr & hit_cmc)
        cfg_reg <= dcc_cfg_t'(PWDATA_I[SW_BIT:0]);
      if (wr & hit_intc)
        intc_reg <= PWDATA_I[7:0];
      if (wr & hit_pen)
        cmp_irq_en_reg <= PWDATA_I[CMP_EN_BIT];
      if (wr & hit_pdir)
        pdir_reg <= PWDATA_I[4:0];
    end
  end

  assign PRDATA_O = rdata_reg;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc & ~mapped;
  assign CFG_O = cfg_reg;
  // analog side compares; digital result high means positive above negative
  assign VREF_TO_POS_O = cfg_reg.mode == MODE_VREF;
  // comparators keep running in sleep unless software picks the off mode
  assign CMP_POWER_DOWN_O = RST_I | (cfg_reg.mode == MODE_OFF);
  assign PA_CMP_SEL_O = cfg_reg.mode == MODE_PINS;
  // raw on purpose: pins see the comparator without synchroniser delay
  assign PA_CMP_OUT_O = PA_CMP_SEL_O ? {CMP2_RAW_I, CMP1_RAW_I} : 2'h0;
  assign PA_OE_O = ~pdir_reg[4:3];
  assign IRQ_O = flag_reg & cmp_irq_en_reg & intc_reg[PERIPH_EN_BIT] & intc_reg[GLOBAL_EN_BIT];
  assign WAKE_O = flag_reg & cmp_irq_en_reg;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  a_flag_on_mismatch: assert property (mismatch |=> flag_reg)
    else $error("flag not set on mismatch");
  a_ref_latch_access: assert property (cmc_access |=> ref_reg == $past(res_s2_reg))
    else $error("reference not latched on access");
  a_flag_sw_clear: assert property (wr && hit_pflags && !PWDATA_I[FLAG_BIT] && !mismatch |=> !flag_reg)
    else $error("flag clear ignored");
  a_flag_sw_set: assert property (wr && hit_pflags && PWDATA_I[FLAG_BIT] |=> flag_reg)
    else $error("flag set lost");
  a_irq_needs_global: assert property (!intc_reg[GLOBAL_EN_BIT] || !cmp_irq_en_reg |-> !IRQ_O)
    else $error("request without enables");
  a_irq_needs_periph: assert property (
    !intc_reg[PERIPH_EN_BIT] |-> !IRQ_O)
    else $error("request without peripheral enable");
  a_irq_all_enabled: assert property (
    flag_reg && cmp_irq_en_reg && intc_reg[PERIPH_EN_BIT] && intc_reg[GLOBAL_EN_BIT] |-> IRQ_O)
    else $error("request missing with all enables set");
  a_wake_on_flag: assert property (
    WAKE_O == (flag_reg && cmp_irq_en_reg))
    else $error("wake request wrong");
  a_result_read: assert property (setup && !PWRITE_I && hit_cmc |=> PRDATA_O[7:6] == $past(res_s2_reg))
    else $error("result bits wrong on read");
  a_sync_two_stage: assert property (res_s2_reg == $past({CMP2_RAW_I, CMP1_RAW_I}, 2))
    else $error("result synchroniser depth wrong");
  a_vref_mode_set: assert property (wr && hit_cmc && PWDATA_I[2:0] == MODE_VREF |=> VREF_TO_POS_O)
    else $error("reference not routed");
  a_pins_raw_out: assert property (PA_CMP_SEL_O |-> PA_CMP_OUT_O == {CMP2_RAW_I, CMP1_RAW_I})
    else $error("pin output not raw result");
  a_oe_direction: assert property (wr && hit_pdir |=> PA_OE_O == ~$past(PWDATA_I[4:3]))
    else $error("direction does not gate drivers");
  a_analog_pdata: assert property (setup && !PWRITE_I && hit_pdata && cfg_reg.mode == MODE_RESET
                                   |=> PRDATA_O[3:0] == 4'h0)
    else $error("analog pin read nonzero");
  a_reset_mode: assert property (disable iff (1'b0) RST_I |-> CMP_POWER_DOWN_O ##1 cfg_reg == CFG_RST)
    else $error("reset state wrong");
  // reference only moves on a control access, so a stale mismatch cannot vanish by itself
  a_ref_hold: assert property (
    !cmc_access |=> ref_reg == $past(ref_reg))
    else $error("reference moved without access");
  a_cfg_hold: assert property (
    !(wr && hit_cmc) |=> cfg_reg == $past(cfg_reg))
    else $error("control changed without write");
  a_cfg_write: assert property (
    wr && hit_cmc |=> cfg_reg == dcc_cfg_t'($past(PWDATA_I[SW_BIT:0])))
    else $error("control write lost");
  a_off_mode_pdown: assert property (
    cfg_reg.mode == MODE_OFF |-> CMP_POWER_DOWN_O)
    else $error("comparators on in off mode");
  a_active_powered: assert property (
    cfg_reg.mode != MODE_OFF |-> !CMP_POWER_DOWN_O)
    else $error("comparators off outside off mode");
  a_pin_sel_mode: assert property (
    PA_CMP_SEL_O == (cfg_reg.mode == MODE_PINS))
    else $error("pin routing in wrong mode");
  a_pins_idle_out: assert property (
    !PA_CMP_SEL_O |-> PA_CMP_OUT_O == 2'h0)
    else $error("pin output driven outside pin mode");
  a_pdata_pin_mode: assert property (
    setup && !PWRITE_I && hit_pdata && cfg_reg.mode == MODE_PINS |=> PRDATA_O[2:0] == 3'h0)
    else $error("analog pin read nonzero in pin mode");
  a_pdata_off_mode: assert property (
    setup && !PWRITE_I && hit_pdata && cfg_reg.mode == MODE_OFF |=> PRDATA_O[4:0] == $past(pin_s2_reg))
    else $error("digital pin read wrong in off mode");
  a_flag_hold: assert property (
    !mismatch && !(wr && hit_pflags) |=> flag_reg == $past(flag_reg))
    else $error("flag moved without cause");
  a_cmc_gap_zero: assert property (
    setup && !PWRITE_I && hit_cmc |=> PRDATA_O[5:4] == 2'h0)
    else $error("unused control bits read nonzero");
  a_rdata_upper: assert property (
    PRDATA_O[DATA_W-1:8] == '0)
    else $error("upper read data nonzero");
endmodule
`default_nettype wire

/* File: verification/dcc_analog_model.sv */
// behavioural model of the two analog comparators in front of the block
`default_nettype none
module dcc_analog_model (
  input wire logic [7:0] pos1_i,
  input wire logic [7:0] neg1_i,
  input wire logic [7:0] pos2_i,
  input wire logic [7:0] neg2_i,
  input wire logic [7:0] vref_i,
  input wire logic vref_sel_i,
  input wire logic pdown_i,
  output logic cmp1_o,
  output logic cmp2_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [7:0] p1 = vref_sel_i ? vref_i : pos1_i;
  wire [7:0] p2 = vref_sel_i ? vref_i : pos2_i;
  // powered-down comparators give a low, never a stale level
  assign cmp1_o = !pdown_i && (p1 > neg1_i);
  assign cmp2_o = !pdown_i && (p2 > neg2_i);
endmodule
`default_nettype wire

/* File: verification/dcc_top_bench.sv */
// self-checking bench of the comparator control block
`default_nettype none
module dcc_top_bench
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, r;
  logic [4:0] pins = 5'h1F;
  logic [7:0] p1 = 8'h00, n1 = 8'h32, p2 = 8'h00, n2 = 8'h96, vref = 8'h64;
  wire c1, c2, vsel, pdn, sel, irq, wake, pready, perr;
  wire [31:0] prdata;
  wire [1:0] pout, poe;
  dcc_cfg_t cfg;
  int errors = 0, cmp_count = 0;
  logic [11:0] ra [5] = '{ADDR_CMC, ADDR_PFLAGS, ADDR_PDIR, ADDR_PEN, ADDR_INTC};
  logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h1F, 8'h00, 8'h00};
  always #4 clk = ~clk;
  dcc_analog_model dcc_analog_model_inst (.pos1_i(p1), .neg1_i(n1), .pos2_i(p2), .neg2_i(n2), .vref_i(vref),
    .vref_sel_i(vsel), .pdown_i(pdn), .cmp1_o(c1), .cmp2_o(c2));
  dcc_top dcc_top_inst (.CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
    .CMP1_RAW_I(c1), .CMP2_RAW_I(c2), .PA_PIN_I(pins), .CFG_O(cfg), .VREF_TO_POS_O(vsel),
    .CMP_POWER_DOWN_O(pdn), .PA_CMP_SEL_O(sel), .PA_CMP_OUT_O(pout), .PA_OE_O(poe), .IRQ_O(irq), .WAKE_O(wake));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  // one apb transfer; the request is held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      close_out();
    end
    r = prdata;
    e = perr;
    psel <= 0;
    pen <= 0;
    // let this edge's updates land before the caller samples
    #1;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    chk(pdn, 1, "power down in reset");
    rst <= 0;
    for (int i = 0; i < 5; i++) begin
      apb(0, ra[i], 0);
      chk(r, {24'h0, rv[i]}, "reset value");
    end
    apb(0, 12'h000, 0);
    chk(r, 0, "unmapped read data");
    chk(e, 1, "unmapped read error");
    $display("test reset done");
    apb(1, ADDR_CMC, 8'hFA);
    chk({vsel, cfg}, 5'h1A, "vref mode");
    repeat (5) @(posedge clk);
    apb(0, ADDR_CMC, 0);
    chk(r, 32'h4A, "control read");
    apb(0, ADDR_PFLAGS, 0);
    chk(r, 32'h40, "flag on mode change");
    apb(1, ADDR_PFLAGS, 0);
    apb(0, ADDR_PFLAGS, 0);
    chk(r, 0, "flag cleared");
    @(posedge clk);
    n1 <= 8'hC8;
    repeat (5) @(posedge clk);
    apb(0, ADDR_PFLAGS, 0);
    chk(r, 32'h40, "flag on change");
    chk(irq, 0, "no request without enables");
    apb(1, ADDR_PFLAGS, 0);
    apb(0, ADDR_PFLAGS, 0);
    chk(r, 32'h40, "mismatch persists");
    apb(0, ADDR_CMC, 0);
    chk(r, 32'h0A, "result latched");
    apb(1, ADDR_PFLAGS, 0);
    apb(0, ADDR_PFLAGS, 0);
    chk(r, 0, "clear after access");
    apb(1, ADDR_PEN, 8'h40);
    apb(1, ADDR_INTC, 8'h40);
    apb(1, ADDR_PFLAGS, 8'h40);
    chk({irq, wake}, 2'b01, "software set, global off");
    apb(1, ADDR_INTC, 8'hC0);
    chk(irq, 1, "all enables");
    apb(1, ADDR_PEN, 0);
    chk({irq, wake}, 2'b00, "comparator enable off");
    $display("test flag done");
    apb(1, ADDR_PDIR, 8'h07);
    apb(1, ADDR_CMC, 8'h06);
    chk({sel, poe}, 3'b111, "pin mode drivers");
    @(posedge clk);
    p1 <= 8'hFF;
    #1;
    chk(pout, 2'b01, "raw result on pins");
    apb(1, ADDR_PDIR, 8'h1F);
    chk(poe, 0, "direction gates drivers");
    apb(0, ADDR_PDATA, 0);
    chk(r, 32'h18, "port read mode 110");
    apb(1, ADDR_CMC, 8'h07);
    chk({pdn, pout}, 3'b100, "comparators off");
    apb(0, ADDR_PDATA, 0);
    chk(r, 32'h1F, "port read mode 111");
    apb(1, ADDR_CMC, 8'h00);
    apb(0, ADDR_PDATA, 0);
    chk(r, 32'h10, "port read mode 000");
    $display("test pins done");
    apb(1, ADDR_CMC, 8'h0B);
    @(posedge clk);
    rst <= 1;
    @(posedge clk);
    #1;
    chk(pdn, 1, "power down in second reset");
    @(posedge clk);
    rst <= 0;
    apb(0, ADDR_CMC, 0);
    chk(r & 32'h3F, 0, "mode after second reset");
    $display("test reset again done");
    close_out();
  end
endmodule
`default_nettype wire
